// File: core/lpom_top.sv
// Purpose: APB register file and output mux for the two indicator pins
// Assumes: all sources on clk_in; APB master keeps the request until pready
// Notes: pins are registered, one cycle after the selection settles
// Functional notes
// - Pin 0 select in bits 2-0 resets to 000, which shows its normal indicator function.
// - Pin 0 codes 010 data match, 011 under-voltage, 100 interrupt, 110 low, 111 high, 001 reserved.
// - Pin 0 code 101 shows the compliance signal picked by the compliance select.
// - Pin 1 select in bits 10-8 resets to 000, which shows its indicator function.
// - Pin 1 decodes like pin 0, with 101 giving the compliance signal.
// - Compliance select in bits 11-9, reset 000, picks one of six compliance signals.
// - Read-write bit 0, reset 0, sets the polarity of pin 0.
// - Read-write bit 3, reset 0, sets the polarity of pin 1.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`include "lpom_map.svh"
module lpom_top (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [1:0] led_func_in,
   input wire logic data_match_in,
   input wire logic undervolt_in,
   input wire logic irq_in,
   input wire logic [5:0] compl_status_in,
   output logic [1:0] led_pin_out
);
   logic [15:0] polcfg_q;
   logic [15:0] srcsel_q;
   logic [1:0] led_q;
   logic valid_q;
   logic [31:0] rdata_q;
   logic err_q;
   logic acc_done;
   logic wr_polcfg;
   logic wr_srcsel;
   logic [15:0] rd_val;
   logic rd_err;
   logic [1:0] level;
   logic [1:0] pol;
   lpom_pkg::lpom_csel_t csel;

   // ==========================================================
   // Byte lane merge of a register write
   function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                              input logic [31:0] wdata,
                                              input logic [3:0] strb,
                                              input logic [15:0] wmask);
      logic [15:0] nv;
      nv = old_v;
      if (strb[0]) begin
         nv[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         nv[15:8] = wdata[15:8];
      end
      return nv & wmask;
   endfunction

   // ==========================================================
   // APB handshake
   // Access completes on the edge where pready is seen
   assign acc_done = psel_in && penable_in && pready_out;
   assign pready_out = psel_in && penable_in && valid_q && ce_in;
   assign prdata_out = rdata_q;
   assign pslverr_out = err_q;
   assign wr_polcfg = acc_done && pwrite_in && (paddr_in == `LPOM_ADDR_POLCFG);
   assign wr_srcsel = acc_done && pwrite_in && (paddr_in == `LPOM_ADDR_SRCSEL);

   // Read data and error decode
   always_comb begin
      rd_val = 16'h0000;
      rd_err = 1'b0;
      if (paddr_in == `LPOM_ADDR_POLCFG) begin
         rd_val = polcfg_q;
      end else if (paddr_in == `LPOM_ADDR_SRCSEL) begin
         rd_val = srcsel_q;
      end else if (paddr_in == `LPOM_ADDR_PINSTAT) begin
         rd_val = {14'h0000, led_q};
      end else begin
         rd_err = 1'b1;
      end
   end

   // Answer captured in the setup cycle, released after access
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         valid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (ce_in) begin
         if (acc_done) begin
            valid_q <= 1'b0;
         end else if (psel_in && !valid_q) begin
            valid_q <= 1'b1;
            rdata_q <= pwrite_in ? 32'h0000_0000 : {16'h0000, rd_val};
            err_q <= rd_err;
         end
      end
   end

   // ==========================================================
   // Configuration registers
   // polarity and compliance write
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         polcfg_q <= `LPOM_POLCFG_RST;
      end else if (ce_in && wr_polcfg) begin
         polcfg_q <= lane_merge(polcfg_q, pwdata_in, pstrb_in, `LPOM_POLCFG_WMASK);
      end
   end

   // source select write, reset to normal function
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         srcsel_q <= `LPOM_SRCSEL_RST;
      end else if (ce_in && wr_srcsel) begin
         srcsel_q <= lane_merge(srcsel_q, pwdata_in, pstrb_in, `LPOM_SRCSEL_WMASK);
      end
   end

   // ==========================================================
   // Pin muxes
   // one compliance select for both pins
   assign csel = lpom_pkg::lpom_csel_t'(polcfg_q[`LPOM_CSEL_MSB:`LPOM_CSEL_LSB]);
   assign pol = {polcfg_q[`LPOM_POL1_BIT], polcfg_q[`LPOM_POL0_BIT]};

   generate
      for (genvar i = 0; i < `LPOM_NUM_PINS; i++) begin : g_pin
         lpom_sel_if u_if ();
         if (i == 0) begin : g_src0
            assign u_if.src =
               lpom_pkg::lpom_src_t'(srcsel_q[`LPOM_SEL0_MSB:`LPOM_SEL0_LSB]);
         end else begin : g_src1
            assign u_if.src =
               lpom_pkg::lpom_src_t'(srcsel_q[`LPOM_SEL1_MSB:`LPOM_SEL1_LSB]);
         end
         assign u_if.csel = csel;
         assign u_if.pol = pol[i];
         assign u_if.func = led_func_in[i];
         assign u_if.match = data_match_in;
         assign u_if.uvolt = undervolt_in;
         assign u_if.irq = irq_in;
         assign u_if.compl = compl_status_in;
         assign level[i] = u_if.level;
         lpom_pin_sel u_sel (
            .sel_if(u_if.mux)
         );
      end
   endgenerate

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         led_q <= 2'b00;
      end else if (ce_in) begin
         led_q <= level;
      end
   end

   assign led_pin_out = led_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   property p_func0;
      (ce_in && srcsel_q[2:0] == 3'b000)
         |=> led_pin_out[0] == ($past(led_func_in[0]) ^ $past(polcfg_q[0]));
   endproperty
   a_func0: assert property (p_func0) else $error("pin 0 not on function");

   property p_match0;
      (ce_in && srcsel_q[2:0] == 3'b010 && !polcfg_q[0])
         |=> led_pin_out[0] == $past(data_match_in);
   endproperty
   a_match0: assert property (p_match0) else $error("pin 0 not on match");

   property p_rsvd0;
      (ce_in && srcsel_q[2:0] == 3'b001) |=> led_pin_out[0] == $past(polcfg_q[0]);
   endproperty
   a_rsvd0: assert property (p_rsvd0) else $error("pin 0 reserved not low");

   property p_compl0;
      (ce_in && srcsel_q[2:0] == 3'b101 && polcfg_q[11:9] == 3'b011 && !polcfg_q[0])
         |=> led_pin_out[0] == $past(compl_status_in[3]);
   endproperty
   a_compl0: assert property (p_compl0) else $error("pin 0 compliance wrong");

   property p_func1;
      (ce_in && srcsel_q[10:8] == 3'b000)
         |=> led_pin_out[1] == ($past(led_func_in[1]) ^ $past(polcfg_q[3]));
   endproperty
   a_func1: assert property (p_func1) else $error("pin 1 not on function");

   property p_irq1;
      (ce_in && srcsel_q[10:8] == 3'b100 && !polcfg_q[3])
         |=> led_pin_out[1] == $past(irq_in);
   endproperty
   a_irq1: assert property (p_irq1) else $error("pin 1 not on interrupt");

   property p_csel_rsvd;
      (ce_in && srcsel_q[10:8] == 3'b101 && polcfg_q[11:10] == 2'b11)
         |=> led_pin_out[1] == $past(polcfg_q[3]);
   endproperty
   a_csel_rsvd: assert property (p_csel_rsvd) else $error("bad compliance code");

   property p_compl1;
      (ce_in && srcsel_q[10:8] == 3'b101 && polcfg_q[11:9] == 3'b101 && !polcfg_q[3])
         |=> led_pin_out[1] == $past(compl_status_in[5]);
   endproperty
   a_compl1: assert property (p_compl1) else $error("pin 1 compliance wrong");

   property p_pol0_wr;
      (wr_polcfg && pstrb_in[0]) |=> polcfg_q[0] == $past(pwdata_in[0]);
   endproperty
   a_pol0_wr: assert property (p_pol0_wr) else $error("pin 0 polarity lost");

   property p_pol1_wr;
      (wr_polcfg && pstrb_in[0]) |=> polcfg_q[3] == $past(pwdata_in[3]);
   endproperty
   a_pol1_wr: assert property (p_pol1_wr) else $error("pin 1 polarity lost");

   property p_invert;
      (ce_in && srcsel_q[2:0] == 3'b111 && polcfg_q[0])
         |=> led_pin_out[0] == 1'b0;
   endproperty
   a_invert: assert property (p_invert) else $error("high not inverted");

   property p_rsvd_bits;
      1'b1 |-> (polcfg_q & ~`LPOM_POLCFG_WMASK) == 16'h0000
         && (srcsel_q & ~`LPOM_SRCSEL_WMASK) == 16'h0000;
   endproperty
   a_rsvd_bits: assert property (p_rsvd_bits) else $error("reserved bit set");

   property p_ready;
      (psel_in && !penable_in && !valid_q && ce_in) ##1 (penable_in && ce_in)
         |-> pready_out;
   endproperty
   a_ready: assert property (p_ready) else $error("no answer in access");

   property p_uvolt0;
      (ce_in && srcsel_q[2:0] == 3'b011 && !polcfg_q[0])
         |=> led_pin_out[0] == $past(undervolt_in);
   endproperty
   a_uvolt0: assert property (p_uvolt0) else $error("pin 0 not on under-voltage");

   property p_irq0;
      (ce_in && srcsel_q[2:0] == 3'b100 && !polcfg_q[0])
         |=> led_pin_out[0] == $past(irq_in);
   endproperty
   a_irq0: assert property (p_irq0) else $error("pin 0 not on interrupt");

   property p_low0;
      (ce_in && srcsel_q[2:0] == 3'b110)
         |=> led_pin_out[0] == $past(polcfg_q[0]);
   endproperty
   a_low0: assert property (p_low0) else $error("pin 0 constant low wrong");

   property p_high0;
      (ce_in && srcsel_q[2:0] == 3'b111 && !polcfg_q[0])
         |=> led_pin_out[0] == 1'b1;
   endproperty
   a_high0: assert property (p_high0) else $error("pin 0 constant high wrong");

   property p_match1;
      (ce_in && srcsel_q[10:8] == 3'b010 && !polcfg_q[3])
         |=> led_pin_out[1] == $past(data_match_in);
   endproperty
   a_match1: assert property (p_match1) else $error("pin 1 not on match");

   property p_uvolt1;
      (ce_in && srcsel_q[10:8] == 3'b011 && !polcfg_q[3])
         |=> led_pin_out[1] == $past(undervolt_in);
   endproperty
   a_uvolt1: assert property (p_uvolt1) else $error("pin 1 not on under-voltage");

   property p_rsvd1;
      (ce_in && srcsel_q[10:8] == 3'b001)
         |=> led_pin_out[1] == $past(polcfg_q[3]);
   endproperty
   a_rsvd1: assert property (p_rsvd1) else $error("pin 1 reserved not low");

   property p_ce_hold;
      !ce_in
         |=> $stable(led_pin_out) && $stable(polcfg_q) && $stable(srcsel_q);
   endproperty
   a_ce_hold: assert property (p_ce_hold) else $error("state moved without enable");

   c_compl0: cover property (srcsel_q[2:0] == 3'b101 && led_pin_out[0]);
   c_inv1: cover property (polcfg_q[3] && srcsel_q[10:8] == 3'b110 && led_pin_out[1]);
   c_err: cover property (pready_out && pslverr_out);
   c_stall: cover property (psel_in && penable_in && !ce_in);
   c_csel_rsvd: cover property (srcsel_q[2:0] == 3'b101 && polcfg_q[11:10] == 2'b11);
endmodule

// File: core/lpom_map.svh
// Purpose: register map, field positions and reset values of the LED pin output mux
// Assumes: 32-bit APB, one aligned word per register, index times four is the byte address
// Notes: definitions only
`ifndef LPOM_MAP_SVH
`define LPOM_MAP_SVH

// ==========================================================
// Register indices and byte addresses
`define LPOM_IDX_POLCFG 14'h0451
`define LPOM_IDX_SRCSEL 14'h0452
`define LPOM_IDX_PINSTAT 14'h0460
`define LPOM_ADDR_POLCFG ({`LPOM_IDX_POLCFG, 2'b00})
`define LPOM_ADDR_SRCSEL ({`LPOM_IDX_SRCSEL, 2'b00})
`define LPOM_ADDR_PINSTAT ({`LPOM_IDX_PINSTAT, 2'b00})

// ==========================================================
// Polarity and compliance configuration fields
`define LPOM_POL0_BIT 0
`define LPOM_POL1_BIT 3
`define LPOM_CSEL_LSB 9
`define LPOM_CSEL_MSB 11
`define LPOM_POLCFG_WMASK 16'h0e09
`define LPOM_POLCFG_RST 16'h0000

// ==========================================================
// Pin source select fields
`define LPOM_SEL0_LSB 0
`define LPOM_SEL0_MSB 2
`define LPOM_SEL1_LSB 8
`define LPOM_SEL1_MSB 10
`define LPOM_SRCSEL_WMASK 16'h0707
`define LPOM_SRCSEL_RST 16'h0000

// ==========================================================
// Widths
`define LPOM_REG_W 16
`define LPOM_NUM_PINS 2
`define LPOM_NUM_COMPL 6

`endif

// File: core/lpom_pkg.sv
// Purpose: types shared by the LED pin output mux
// Assumes: nothing beyond the map header
// Notes: codes match the source and compliance select fields
package lpom_pkg;

   // ==========================================================
   // Pin source select codes
   typedef enum logic [2:0] {
      LPOM_SRC_FUNC  = 3'b000,
      LPOM_SRC_RSVD  = 3'b001,
      LPOM_SRC_MATCH = 3'b010,
      LPOM_SRC_UVOLT = 3'b011,
      LPOM_SRC_IRQ   = 3'b100,
      LPOM_SRC_COMPL = 3'b101,
      LPOM_SRC_LOW   = 3'b110,
      LPOM_SRC_HIGH  = 3'b111
   } lpom_src_t;

   // ==========================================================
   // Compliance signal select codes, 110 and 111 unused
   typedef enum logic [2:0] {
      LPOM_CS_LOC_RCVR  = 3'b000,
      LPOM_CS_REM_RCVR  = 3'b001,
      LPOM_CS_LOC_SNR   = 3'b010,
      LPOM_CS_REM_READY = 3'b011,
      LPOM_CS_PMA_WDOG  = 3'b100,
      LPOM_CS_LINK_SYNC = 3'b101
   } lpom_csel_t;

endpackage

// File: core/lpom_sel_if.sv
// Purpose: carries the sources and settings of one indicator pin to its mux
// Assumes: all signals on the register clock
// Notes: level is combinational, registered by the top
`timescale 1ns/100ps
interface lpom_sel_if;
   lpom_pkg::lpom_src_t src;
   lpom_pkg::lpom_csel_t csel;
   logic pol;
   logic func;
   logic match;
   logic uvolt;
   logic irq;
   logic [5:0] compl;
   logic level;

   // Mux side and control side
   modport mux (input src, csel, pol, func, match, uvolt, irq, compl, output level);
   modport ctl (output src, csel, pol, func, match, uvolt, irq, compl, input level);
endinterface

// File: core/lpom_pin_sel.sv
// Purpose: source mux and polarity for one indicator pin
// Assumes: select values already registered by the top
// Notes: purely combinational
`timescale 1ns/100ps
module lpom_pin_sel (
   lpom_sel_if.mux sel_if
);
   logic raw;
   logic compl_bit;

   always_comb begin
      case (sel_if.csel)
         lpom_pkg::LPOM_CS_LOC_RCVR: compl_bit = sel_if.compl[0];
         lpom_pkg::LPOM_CS_REM_RCVR: compl_bit = sel_if.compl[1];
         lpom_pkg::LPOM_CS_LOC_SNR: compl_bit = sel_if.compl[2];
         lpom_pkg::LPOM_CS_REM_READY: compl_bit = sel_if.compl[3];
         lpom_pkg::LPOM_CS_PMA_WDOG: compl_bit = sel_if.compl[4];
         lpom_pkg::LPOM_CS_LINK_SYNC: compl_bit = sel_if.compl[5];
         default: compl_bit = 1'b0;
      endcase
   end

   always_comb begin
      unique case (sel_if.src)
         lpom_pkg::LPOM_SRC_FUNC: raw = sel_if.func;
         lpom_pkg::LPOM_SRC_RSVD: raw = 1'b0;
         lpom_pkg::LPOM_SRC_MATCH: raw = sel_if.match;
         lpom_pkg::LPOM_SRC_UVOLT: raw = sel_if.uvolt;
         lpom_pkg::LPOM_SRC_IRQ: raw = sel_if.irq;
         lpom_pkg::LPOM_SRC_COMPL: raw = compl_bit;
         lpom_pkg::LPOM_SRC_LOW: raw = 1'b0;
         lpom_pkg::LPOM_SRC_HIGH: raw = 1'b1;
      endcase
   end

   assign sel_if.level = raw ^ sel_if.pol;
endmodule

// File: bench/led_pin_output_mux_bench.sv
// Purpose: self-checking bench of the LED pin output mux
// Assumes: APB master waits for pready; all sources on clk_in
// Notes: sources are randomised every cycle unless frozen
`timescale 1ns/100ps
`include "lpom_map.svh"
module led_pin_output_mux_bench;
   // ==========================================================
   // Signals and model state
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [15:0] paddr = 16'h0000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata;
   logic pready, pslverr;
   logic [1:0] func = 2'h0;
   logic match = 1'b0;
   logic uv = 1'b0;
   logic irq = 1'b0;
   logic [5:0] compl = 6'h00;
   logic [1:0] pins, exp_n;
   logic exp_ok = 1'b0;
   logic frz = 1'b0;
   logic ce = 1'b1;
   logic [15:0] pol_m = 16'h0000;
   logic [15:0] sel_m = 16'h0000;
   int error_cnt = 0;
   int cmp_count = 0;

   // Clock, 50 ns period
   always #25 clk_in = ~clk_in;

   lpom_top dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .led_func_in(func), .data_match_in(match),
      .undervolt_in(uv), .irq_in(irq), .compl_status_in(compl), .led_pin_out(pins));

   // ==========================================================
   // Behavioural model of one pin
   function automatic logic pin_val(input int i);
      logic [2:0] s;
      logic v;
      s = (i == 0) ? sel_m[2:0] : sel_m[10:8];
      case (s)
         3'h0: v = func[i];
         3'h2: v = match;
         3'h3: v = uv;
         3'h4: v = irq;
         3'h5: v = (pol_m[11:9] < 3'h6) ? compl[pol_m[11:9]] : 1'b0;
         3'h7: v = 1'b1;
         default: v = 1'b0;
      endcase
      return v ^ pol_m[i * 3];
   endfunction

   // Masked write of a model register
   function automatic logic [15:0] wm(input logic [15:0] o, input logic [31:0] d,
                                      input logic [3:0] s, input logic [15:0] m);
      logic [15:0] b;
      b = {{8{s[1]}}, {8{s[0]}}} & m;
      return (o & ~b) | (d[15:0] & b);
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string m);
      cmp_count++;
      if (got !== ex) begin
         error_cnt++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, ex);
      end
   endtask

   task automatic end_sim;
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================
   // Random sources and pin monitor
   always @(posedge clk_in) begin
      if (!frz) {func, match, uv, irq, compl} <= 11'($urandom);
   end

   // Expected pins from the settled cycle, held while enable is low
   always @(negedge clk_in) begin
      if (ce) exp_n = {pin_val(1), pin_val(0)};
      exp_ok = !rst_in;
   end

   // Pins compared one edge later
   always @(posedge clk_in) begin
      #1;
      if (exp_ok && !rst_in) chk(32'(pins), 32'(exp_n), "pin level");
   end

   // ==========================================================
   // APB transfer with model update
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic er);
      int n;
      n = 0;
      @(posedge clk_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk_in);
      pen <= 1'b1;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         chk(32'h0, 32'h1, "no ready");
         end_sim;
      end
      rd = prdata;
      er = pslverr;
      if (w && a == `LPOM_ADDR_POLCFG) pol_m = wm(pol_m, d, s, `LPOM_POLCFG_WMASK);
      if (w && a == `LPOM_ADDR_SRCSEL) sel_m = wm(sel_m, d, s, `LPOM_SRCSEL_WMASK);
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   // Read one address and compare data and error
   task automatic rd_chk(input logic [15:0] a);
      logic [31:0] rd, ex;
      logic er, bad;
      bad = !(a inside {`LPOM_ADDR_POLCFG, `LPOM_ADDR_SRCSEL, `LPOM_ADDR_PINSTAT});
      ex = (a == `LPOM_ADDR_POLCFG) ? 32'(pol_m) : (a == `LPOM_ADDR_SRCSEL) ?
           32'(sel_m) : (a == `LPOM_ADDR_PINSTAT) ? 32'(exp_n) : 32'h0;
      apb(1'b0, a, 32'h0, 4'hf, rd, er);
      chk(rd, ex, "read data");
      chk(32'(er), 32'(bad), "read error");
   endtask

   // All registers with sources frozen
   task automatic rd_all;
      frz = 1'b1;
      repeat (3) @(posedge clk_in);
      rd_chk(`LPOM_ADDR_POLCFG);
      rd_chk(`LPOM_ADDR_SRCSEL);
      rd_chk(`LPOM_ADDR_PINSTAT);
      rd_chk(16'h1000);
      frz = 1'b0;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      logic [31:0] d, rd;
      logic er;
      void'($urandom(32'hb650));
      repeat (12) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_all;
      // Every code of both pins, every compliance pick, all polarities
      for (int s = 0; s < 8; s++) begin
         for (int c = 0; c < 8; c++) begin
            for (int p = 0; p < 4; p++) begin
               d = $urandom;
               d[2:0] = 3'(s);
               d[10:8] = 3'(s + c);
               apb(1'b1, `LPOM_ADDR_SRCSEL, d, (p == 3) ? 4'($urandom) : 4'hf, rd, er);
               d = $urandom;
               d[11:9] = 3'(c);
               d[0] = p[0];
               d[3] = p[1];
               apb(1'b1, `LPOM_ADDR_POLCFG, d, 4'hf, rd, er);
               repeat (3) @(posedge clk_in);
            end
         end
         rd_all;
      end
      // Writes to read-only and unmapped places
      apb(1'b1, `LPOM_ADDR_PINSTAT, $urandom, 4'hf, rd, er);
      chk(32'(er), 32'h0, "status write error");
      apb(1'b1, 16'h1000, $urandom, 4'hf, rd, er);
      chk(32'(er), 32'h1, "unmapped write error");
      rd_all;
      // Enable low freezes the pins and stalls an access until it returns
      @(posedge clk_in);
      ce <= 1'b0;
      repeat (5) @(posedge clk_in);
      fork
         rd_chk(`LPOM_ADDR_SRCSEL);
         begin
            repeat (4) @(posedge clk_in);
            ce <= 1'b1;
         end
      join
      // Reset in mid-run restores defaults
      @(posedge clk_in);
      rst_in <= 1'b1;
      pol_m = 16'h0000;
      sel_m = 16'h0000;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      rd_all;
      repeat (4) @(posedge clk_in);
      end_sim;
   end
endmodule
